// >>> hw/mmas_acq_sync.v
`timescale 1ns/1ps
`include "mmas_defines.vh"
// Behaviour
// - Mode input selects master, slave or none; other codes act as none.
// - Master drives trigger and sample clock onto the link.
// - Slave takes trigger and clock from the link.
// - Slave ignores local start trigger, uses link trigger instead.
// - None is reset default, uses local clock, link untouched.
// - Mode is latched and held until reprogrammed or session ends.
// - Master fires from any source and forwards its trigger on the link.
// - Master and slave start within one conversion period.
// - Each module programs its own sample rate divider.
// - Slave with link reference trigger switches pre to post capture.
module mmas_acq_sync (
  input  wire        clock,
  input  wire        rst,
  input  wire [1:0]  modeIn,
  input  wire        modeLoad,
  input  wire        sessionEnd,
  input  wire [1:0]  startSrc,
  input  wire [1:0]  refSrc,
  input  wire [15:0] rateDiv,
  input  wire        rateLoad,
  input  wire        arm,
  input  wire        disarm,
  input  wire        softTrig,
  input  wire        extTrigPin,
  input  wire        threshTrig,
  input  wire        refExtTrig,
  input  wire        refThreshTrig,
  input  wire        linkTrigIn,
  input  wire        linkClkIn,
  output reg         linkTrigOut,
  output reg         linkTrigOe,
  output reg         linkClkOut,
  output reg         linkClkOe,
  output reg         sampleStrobe,
  output reg         acqRunning,
  output reg         postTrigger,
  output wire [1:0]  syncMode
);
  reg  [1:0]             mode;
  reg  [1:0]             state;
  reg  [`MMAS_DIV_W-1:0] divReload;
  reg  [`MMAS_DIV_W-1:0] divCount;
  reg                    localTick;
  reg                    trigHold;
  wire                   extRise;
  wire                   refExtRise;
  wire                   linkTrigRise;
  wire                   linkClkRise;
  wire                   isMaster;
  wire                   isSlave;
  wire                   startEvent;
  wire                   refEvent;
  wire                   paceTick;
  reg                    localStart;

  // Acquisition state codes, binary encoded.
  localparam [1:0] ST_IDLE = `MMAS_ST_IDLE;
  localparam [1:0] ST_PRE  = `MMAS_ST_PRE;
  localparam [1:0] ST_POST = `MMAS_ST_POST;

  // Every pin-level input passes two flops before logic reads it.
  mmas_sync2 uExt (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (extTrigPin),
    .syncOut (),
    .riseOut (extRise)
  );
  mmas_sync2 uRefExt (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (refExtTrig),
    .syncOut (),
    .riseOut (refExtRise)
  );
  mmas_sync2 uLinkTrig (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (linkTrigIn),
    .syncOut (),
    .riseOut (linkTrigRise)
  );
  mmas_sync2 uLinkClk (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (linkClkIn),
    .syncOut (),
    .riseOut (linkClkRise)
  );

  // Mode register: defaults to none, held until reloaded or the session ends.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode <= `MMAS_MODE_NONE;
    end else if (sessionEnd) begin
      mode <= `MMAS_MODE_NONE;
    end else if (modeLoad) begin
      if (modeIn == `MMAS_MODE_MASTER || modeIn == `MMAS_MODE_SLAVE) begin
        mode <= modeIn;
      end else begin
        mode <= `MMAS_MODE_NONE;
      end
    end
  end

  assign syncMode = mode;
  assign isMaster = (mode == `MMAS_MODE_MASTER);
  assign isSlave  = (mode == `MMAS_MODE_SLAVE);

  // Per-module rate divider reload value.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      divReload <= `MMAS_DIV_RESET;
    end else if (rateLoad) begin
      divReload <= rateDiv;
    end
  end

  // Local pacing counter; restarts on the start event so pacing aligns to it.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      divCount  <= {`MMAS_DIV_W{1'b0}};
      localTick <= 1'b0;
    end else if (startEvent || divCount == {`MMAS_DIV_W{1'b0}}) begin
      divCount  <= divReload;
      localTick <= ~startEvent;
    end else begin
      divCount  <= divCount - 1'b1;
      localTick <= 1'b0;
    end
  end

  // Local start trigger selection, used only outside slave mode.
  always @* begin
    case (startSrc)
      `MMAS_TRIG_SOFT:   localStart = softTrig;
      `MMAS_TRIG_EXT:    localStart = extRise;
      `MMAS_TRIG_THRESH: localStart = threshTrig;
      default:           localStart = softTrig;
    endcase
  end

  // Slave starts on the link trigger only; others use the local source.
  assign startEvent = (state == ST_IDLE) &&
                      (isSlave ? linkTrigRise : localStart);

  // Reference trigger; link reference is honoured only in slave mode.
  assign refEvent = (state == ST_PRE) &&
                    ((refSrc == `MMAS_REF_EXT && refExtRise) ||
                     (refSrc == `MMAS_REF_THRESH && refThreshTrig) ||
                     (refSrc == `MMAS_REF_LINK && isSlave && linkTrigRise));

  // Slave paces from link clock edges, others from the local divider.
  assign paceTick = isSlave ? linkClkRise : localTick;

  // Acquisition state: idle until armed start, pre-trigger, then post-trigger.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (disarm || modeLoad) begin
      // A mode load aborts the run so no start carries over into the new mode.
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (arm && startEvent) begin
            state <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (refEvent) begin
            state <= ST_POST;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // Master holds the forwarded trigger high for one local sample period.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      trigHold <= 1'b0;
    end else if (isMaster && startEvent && arm) begin
      trigHold <= 1'b1;
    end else if (localTick || !isMaster) begin
      trigHold <= 1'b0;
    end
  end

  // Registered outputs toward the link and the converters.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      linkTrigOut  <= 1'b0;
      linkTrigOe   <= 1'b0;
      linkClkOut   <= 1'b0;
      linkClkOe    <= 1'b0;
      sampleStrobe <= 1'b0;
      acqRunning   <= 1'b0;
      postTrigger  <= 1'b0;
    end else begin
      linkTrigOe   <= isMaster;
      linkClkOe    <= isMaster;
      linkTrigOut  <= isMaster & (trigHold | (startEvent & arm));
      // The forwarded clock rises on each local tick and falls at half the reload count.
      if (!isMaster) begin
        linkClkOut <= 1'b0;
      end else if (localTick) begin
        linkClkOut <= 1'b1;
      end else if (divCount == {1'b0, divReload[`MMAS_DIV_W-1:1]}) begin
        linkClkOut <= 1'b0;
      end
      sampleStrobe <= paceTick && (state != ST_IDLE);
      acqRunning   <= (state != ST_IDLE);
      postTrigger  <= (state == ST_POST);
    end
  end
endmodule // mmas_acq_sync

// >>> pkg/mmas_defines.vh
`ifndef MMAS_DEFINES_VH
`define MMAS_DEFINES_VH

// Synchronization mode encodings.
`define MMAS_MODE_NONE      2'h0
`define MMAS_MODE_MASTER    2'h1
`define MMAS_MODE_SLAVE     2'h2

// Start trigger source encodings.
`define MMAS_TRIG_SOFT      2'h0
`define MMAS_TRIG_EXT       2'h1
`define MMAS_TRIG_THRESH    2'h2

// Reference trigger source encodings.
`define MMAS_REF_EXT        2'h0
`define MMAS_REF_THRESH     2'h1
`define MMAS_REF_LINK       2'h2

// Sample clock divider width and reset values.
`define MMAS_DIV_W          16
`define MMAS_DIV_RESET      16'h0009

// Acquisition state codes.
`define MMAS_ST_IDLE        2'h0
`define MMAS_ST_PRE         2'h1
`define MMAS_ST_POST        2'h2

`endif

// >>> hw/mmas_sync2.v
`timescale 1ns/1ps
// Two-stage synchronizer with rising-edge detector on the second stage output.
module mmas_sync2 (
  input  wire clock,
  input  wire rst,
  input  wire asyncIn,
  output wire syncOut,
  output wire riseOut
);
  reg stage1;
  reg stage2;
  reg stage3;

  // Only stage2 reads stage1; edge logic looks at stage2 and stage3.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign syncOut = stage2;
  assign riseOut = stage2 & ~stage3;
endmodule // mmas_sync2

// >>> sim/mmas_partner.sv
`timescale 1ns/1ps
// Far module acting as master: fires the link trigger and runs the link clock.
module mmas_partner (
  input  wire fire,
  output reg  linkTrig,
  output reg  linkClk
);
  // Both lines start low.
  initial begin
    linkTrig = 1'b0;
    linkClk = 1'b0;
  end
  // Each rise of fire sends one trigger pulse of two link periods.
  always @(posedge fire) begin
    linkTrig = 1'b1;
    #400 linkTrig = 1'b0;
  end
  // The 200 ns link clock runs only while fired and rests low otherwise.
  always begin
    wait (fire);
    #100 linkClk = fire & ~linkClk;
  end
endmodule // mmas_partner

// >>> sim/mmas_acq_sync_monitor.sv
`timescale 1ns/1ps
// Watches mode handling, link drive and pacing at the block's ports.
module mmas_acq_sync_monitor (
  input wire       clock,
  input wire       rst,
  input wire [1:0] modeIn,
  input wire       modeLoad,
  input wire       sessionEnd,
  input wire [1:0] refSrc,
  input wire       linkClkIn,
  input wire       linkTrigOut,
  input wire       linkTrigOe,
  input wire       linkClkOe,
  input wire       sampleStrobe,
  input wire       acqRunning,
  input wire       postTrigger,
  input wire [1:0] syncMode
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Mode latching, link drive, trigger forwarding and slave pacing.
  property p_ld; modeLoad |=> syncMode == (&$past(modeIn) ? 2'h0 : $past(modeIn)); endproperty
  property p_hold; !modeLoad && !sessionEnd |=> $stable(syncMode); endproperty
  property p_end; sessionEnd && !modeLoad |=> syncMode == 2'h0; endproperty
  property p_quiet; syncMode != 2'h1 ##1 syncMode != 2'h1 |-> !(linkTrigOe || linkClkOe); endproperty
  property p_drive; syncMode == 2'h1 ##1 syncMode == 2'h1 |-> linkTrigOe && linkClkOe; endproperty
  property p_fwd; $rose(acqRunning) && syncMode == 2'h1 |-> linkTrigOut; endproperty
  property p_pace; sampleStrobe && syncMode == 2'h2 |-> $past(linkClkIn, 3); endproperty
  property p_ref; $rose(postTrigger) && refSrc == 2'h2 |-> syncMode == 2'h2; endproperty
  a_ld: assert property (p_ld) else $error("mode load wrong");
  a_hold: assert property (p_hold) else $error("mode drifted");
  a_end: assert property (p_end) else $error("session end kept mode");
  a_quiet: assert property (p_quiet) else $error("link driven off master");
  a_drive: assert property (p_drive) else $error("master not driving");
  a_fwd: assert property (p_fwd) else $error("trigger not forwarded");
  a_pace: assert property (p_pace) else $error("slave strobe not from link");
  a_ref: assert property (p_ref) else $error("link ref outside slave");
  cover property ($rose(acqRunning) && syncMode == 2'h2);
  cover property ($rose(acqRunning) && syncMode == 2'h1);
  cover property ($rose(postTrigger));
endmodule // mmas_acq_sync_monitor

// >>> sim/tb_mmas_acq_sync.sv
`timescale 1ns/1ps
// Bench: mode table first, then start, pacing and link cases.
module tb_mmas_acq_sync;
  reg         clock, rst, modeLoad, sessionEnd, rateLoad, arm, disarm, fire;
  reg         softTrig, extTrigPin, threshTrig, refThreshTrig, prevClk;
  reg  [1:0]  modeIn, startSrc, refSrc;
  reg  [15:0] rateDiv;
  reg  [4:0]  rows [0:3];
  wire        linkTrigOut, linkTrigOe, linkClkOut, linkClkOe, sampleStrobe;
  wire        acqRunning, postTrigger, farTrig, farClk, lt, lc;
  wire [1:0]  syncMode;
  integer     fail_count, cmp_count, cyc, i, n, k;
  // The far module owns the lines unless this one drives them.
  assign lt = linkTrigOe ? linkTrigOut : farTrig;
  assign lc = linkClkOe ? linkClkOut : farClk;
  mmas_acq_sync dut (.clock, .rst, .modeIn, .modeLoad, .sessionEnd, .startSrc, .refSrc,
    .rateDiv, .rateLoad, .arm, .disarm, .softTrig, .extTrigPin, .threshTrig,
    .refExtTrig(1'b0), .refThreshTrig, .linkTrigIn(lt), .linkClkIn(lc), .linkTrigOut,
    .linkTrigOe, .linkClkOut, .linkClkOe, .sampleStrobe, .acqRunning, .postTrigger, .syncMode);
  mmas_partner far (.fire, .linkTrig(farTrig), .linkClk(farClk));
  // Clock and cycle ceiling.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  task step(input integer k); begin
    repeat (k) @(posedge clock);
    #2;
  end endtask
  task chk(input string nm, input [15:0] e, input [15:0] g); begin
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  end endtask
  task ld(input [1:0] m); begin
    modeIn = m;
    modeLoad = 1'b1;
    step(1);
    modeLoad = 1'b0;
    step(2);
  end endtask
  task close_out; begin
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  // Main sequence; rows hold {modeIn, syncMode, link enable}.
  initial begin
    {modeLoad, sessionEnd, rateLoad, arm, disarm, fire, softTrig, extTrigPin, threshTrig} = 9'h000;
    {modeIn, startSrc, refSrc, rateDiv} = 22'h00_0000;
    rst = 1'b1;
    refThreshTrig = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    rows[0] = 5'h00;
    rows[1] = 5'h0B;
    rows[2] = 5'h14;
    rows[3] = 5'h18;
    step(5);
    rst = 1'b0;
    chk("syncMode", 16'h0000, syncMode);
    chk("linkTrigOe", 16'h0000, linkTrigOe);
    for (i = 0; i < 4; i = i + 1) begin
      ld(rows[i][4:3]);
      chk("syncMode", rows[i][2:1], syncMode);
      chk("linkClkOe", rows[i][0], linkClkOe);
      chk("linkTrigOe", rows[i][0], linkTrigOe);
    end
    rateDiv = 16'h0004;
    rateLoad = 1'b1;
    step(1);
    rateLoad = 1'b0;
    ld(2'h1);
    for (i = 0; i < 3; i = i + 1) begin
      startSrc = i[1:0];
      arm = 1'b1;
      softTrig = (i == 0);
      extTrigPin = (i == 1);
      threshTrig = (i == 2);
      step(1);
      {softTrig, threshTrig} = 2'h0;
      for (n = 0; acqRunning !== 1'b1 && n < 60; n = n + 1) step(1);
      extTrigPin = 1'b0;
      chk("linkTrigOut", 16'h0001, linkTrigOut);
      for (n = 0; sampleStrobe !== 1'b1 && n < 20; n = n + 1) step(1);
      chk("firstStrobe", 16'h0005, n[15:0]);
      step(1);
      for (n = 1; sampleStrobe !== 1'b1 && n < 20; n = n + 1) step(1);
      chk("strobeGap", 16'h0005, n[15:0]);
      // Forwarded link clock: one rise per local tick, so two in ten cycles.
      prevClk = linkClkOut;
      k = 0;
      repeat (10) begin
        step(1);
        k = k + (linkClkOut & ~prevClk);
        prevClk = linkClkOut;
      end
      chk("linkClkRises", 16'h0002, k[15:0]);
      {arm, disarm} = 2'h1;
      step(1);
      disarm = 1'b0;
      step(2);
      chk("acqRunning", 16'h0000, acqRunning);
    end
    // Threshold reference trigger in master mode moves the run to post-trigger.
    {startSrc, refSrc, arm, softTrig} = 6'h07;
    step(1);
    softTrig = 1'b0;
    step(3);
    refThreshTrig = 1'b1;
    step(1);
    refThreshTrig = 1'b0;
    step(2);
    chk("postTrigger", 16'h0001, postTrigger);
    arm = 1'b0;
    ld(2'h2);
    {startSrc, refSrc, arm, softTrig} = 6'h0B;
    step(1);
    softTrig = 1'b0;
    step(10);
    chk("acqRunning", 16'h0000, acqRunning);
    fire = 1'b1;
    for (n = 0; acqRunning !== 1'b1 && n < 60; n = n + 1) step(1);
    chk("acqRunning", 16'h0001, acqRunning);
    step(8);
    n = 0;
    repeat (32) begin
      n = n + (sampleStrobe === 1'b1);
      step(1);
    end
    chk("linkStrobes", 16'h0004, n);
    fire = 1'b0;
    step(4);
    fire = 1'b1;
    for (n = 0; postTrigger !== 1'b1 && n < 40; n = n + 1) step(1);
    chk("postTrigger", 16'h0001, postTrigger);
    {sessionEnd, fire} = 2'h2;
    step(1);
    sessionEnd = 1'b0;
    chk("syncMode", 16'h0000, syncMode);
    close_out;
  end
endmodule // tb_mmas_acq_sync
bind mmas_acq_sync mmas_acq_sync_monitor mon (.clock, .rst, .modeIn, .modeLoad, .sessionEnd,
  .refSrc, .linkClkIn, .linkTrigOut, .linkTrigOe, .linkClkOe, .sampleStrobe, .acqRunning,
  .postTrigger, .syncMode);
